// ==== shared/awd_pkg.sv ====
// constants and types shared by the window detector and its converter sequencer
package awd_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned MCLK_KHZ        = 200000;
    localparam int unsigned SAR_CLK_MAX_KHZ = 2500;
    // shortest sar clock period, so the divide rounds up
    localparam int unsigned SAR_DIV         = (MCLK_KHZ + SAR_CLK_MAX_KHZ - 1) / SAR_CLK_MAX_KHZ;
    localparam logic [6:0]  SAR_DIV_LAST    = 7'(SAR_DIV - 1);
    localparam int unsigned CONV_SAR_CLKS   = 16;
    localparam logic [3:0]  CONV_LAST       = 4'(CONV_SAR_CLKS - 1);
    localparam logic [3:0]  SAR_BITS        = 4'h8;
    localparam logic [7:0]  SAR_MSB_MASK    = 8'h80;
    localparam int unsigned CONV_CYCLES     = SAR_DIV * CONV_SAR_CLKS;

    // ------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [9:0]  IDX_RESULT      = 10'h0BF;
    localparam logic [9:0]  IDX_CTRL        = 10'h0C0;
    localparam logic [9:0]  IDX_GT          = 10'h0C6;
    localparam logic [9:0]  IDX_LT          = 10'h0C7;
    localparam logic [9:0]  IDX_ISTAT       = 10'h0D0;
    localparam logic [9:0]  IDX_ICLR        = 10'h0D1;
    localparam logic [9:0]  IDX_IEN         = 10'h0D2;
    localparam logic [9:0]  IDX_NONE        = 10'h3FF;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned CTRL_WIN_BIT    = 1;
    localparam int unsigned CTRL_BUSY_BIT   = 4;
    localparam int unsigned CTRL_DONE_BIT   = 5;
    localparam int unsigned EV_DONE         = 0;
    localparam int unsigned EV_WIN          = 1;
    localparam logic [7:0]  LIMIT_RST       = 8'h00;
    localparam logic [1:0]  IEN_RST         = 2'h0;
    localparam logic [1:0]  HRESP_OKAY      = 2'h0;

    typedef struct packed {
        logic       eoc;
        logic [7:0] code;
    } awd_conv_t;

    typedef enum logic {SAR_IDLE, SAR_CONV} awd_sar_state_t;
endpackage : awd_pkg

// ==== design/awd_sar.sv ====
// successive-approximation sequencer: sixteen sar clocks per conversion
`timescale 1ns/1ps
module awd_sar (
    input  wire logic             i_mclk,
    input  wire logic             i_nrst,
    input  wire logic             i_start,
    input  wire logic [7:0]       i_ain_code,
    output logic                  o_busy,
    output awd_pkg::awd_conv_t    o_conv
);
    logic [7:0]              ain_s1_r;
    logic [7:0]              ain_s2_r;
    awd_pkg::awd_sar_state_t state_r, state_nxt;
    logic [6:0]              div_r, div_nxt;
    logic [3:0]              cnt_r, cnt_nxt;
    logic [7:0]              code_r, code_nxt;
    logic [7:0]              mask_r, mask_nxt;
    logic                    busy_r, busy_nxt;
    awd_pkg::awd_conv_t      conv_r, conv_nxt;
    logic                    tick;
    logic [7:0]              trial;

    assign tick  = (div_r == awd_pkg::SAR_DIV_LAST);
    assign trial = code_r | mask_r;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_nxt     = state_r;
        div_nxt       = div_r;
        cnt_nxt       = cnt_r;
        code_nxt      = code_r;
        mask_nxt      = mask_r;
        busy_nxt      = busy_r;
        conv_nxt.eoc  = 1'b0;
        conv_nxt.code = conv_r.code;
        case (state_r)
            awd_pkg::SAR_IDLE: begin
                if (i_start) begin
                    state_nxt = awd_pkg::SAR_CONV;
                    div_nxt   = 7'h00;
                    cnt_nxt   = 4'h0;
                    code_nxt  = 8'h00;
                    mask_nxt  = awd_pkg::SAR_MSB_MASK;
                    busy_nxt  = 1'b1;
                end
            end
            awd_pkg::SAR_CONV: begin
                div_nxt = tick ? 7'h00 : div_r + 7'h01;
                if (tick) begin
                    // bits resolve first, the rest of the sixteen clocks pad out the conversion
                    if (cnt_r < awd_pkg::SAR_BITS) begin
                        code_nxt = (ain_s2_r >= trial) ? trial : code_r;
                        mask_nxt = mask_r >> 1;
                    end
                    if (cnt_r == awd_pkg::CONV_LAST) begin
                        state_nxt     = awd_pkg::SAR_IDLE;
                        busy_nxt      = 1'b0;
                        conv_nxt.eoc  = 1'b1;
                        conv_nxt.code = code_r;
                    end else begin
                        cnt_nxt = cnt_r + 4'h1;
                    end
                end
            end
            default: begin
                state_nxt = awd_pkg::SAR_IDLE;
                busy_nxt  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            ain_s1_r <= 8'h00;
            ain_s2_r <= 8'h00;
            state_r  <= awd_pkg::SAR_IDLE;
            div_r    <= 7'h00;
            cnt_r    <= 4'h0;
            code_r   <= 8'h00;
            mask_r   <= 8'h00;
            busy_r   <= 1'b0;
            conv_r   <= '0;
        end else begin
            ain_s1_r <= i_ain_code;
            ain_s2_r <= ain_s1_r;
            state_r  <= state_nxt;
            div_r    <= div_nxt;
            cnt_r    <= cnt_nxt;
            code_r   <= code_nxt;
            mask_r   <= mask_nxt;
            busy_r   <= busy_nxt;
            conv_r   <= conv_nxt;
        end
    end

    assign o_busy = busy_r;
    assign o_conv = conv_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    localparam int CYC_I = awd_pkg::CONV_CYCLES;
    logic [10:0] cyc_r;
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            cyc_r <= 11'h000;
        end else begin
            cyc_r <= busy_r ? cyc_r + 11'h001 : 11'h000;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    chk_conv_length: assert property (conv_r.eoc |-> cyc_r == 11'(CYC_I))
        else $error("conversion did not take sixteen sar clocks");
    chk_eoc_single: assert property (conv_r.eoc |=> !conv_r.eoc)
        else $error("end of conversion longer than one cycle");
    chk_busy_start: assert property (i_start && !busy_r |=> busy_r [*8])
        else $error("start did not begin a conversion");
endmodule : awd_sar

// ==== design/awd_top.sv ====
// window detector on an 8-bit converter, registers on ahb-lite
`timescale 1ns/1ps
module awd_top (
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    input  wire logic [7:0]  i_ain_code,
    output logic [31:0]      o_hrdata,
    output logic             o_hreadyout,
    output logic [1:0]       o_hresp,
    output logic             o_irq
);
    logic               dp_wr_r, dp_wr_nxt;
    logic [9:0]         dp_idx_r, dp_idx_nxt;
    logic [31:0]        hrdata_r, hrdata_nxt;
    logic               hready_r;
    logic [1:0]         hresp_r;
    logic [7:0]         gt_r, gt_nxt;
    logic [7:0]         lt_r, lt_nxt;
    logic [7:0]         result_r, result_nxt;
    logic               win_r, win_nxt;
    logic               done_r, done_nxt;
    logic [1:0]         ien_r, ien_nxt;
    logic               irq_r, irq_nxt;
    logic               start_r, start_nxt;
    logic               busy;
    awd_pkg::awd_conv_t conv;
    logic               ap_valid;
    logic               ap_mapped;
    logic               match;
    logic               win_clr;
    logic               done_clr;
    logic               wr_ctrl;

    // ------------------------------------------------------------
    // converter
    // ------------------------------------------------------------
    awd_sar u_sar (
        .i_mclk     (i_mclk),
        .i_nrst     (i_nrst),
        .i_start    (start_r),
        .i_ain_code (i_ain_code),
        .o_busy     (busy),
        .o_conv     (conv)
    );

    // ------------------------------------------------------------
    // window compare
    // ------------------------------------------------------------
    always_comb begin
        if (lt_r <= gt_r) begin
            match = (conv.code < lt_r) || (conv.code > gt_r);
        end else begin
            match = (conv.code > gt_r) && (conv.code < lt_r);
        end
    end

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign ap_valid  = i_hsel && i_hready && i_htrans[1];
    // only word-aligned addresses are served; hsize is checked only to reject a value of 7
    assign ap_mapped = (i_haddr[31:12] == 20'h00000) && (i_haddr[1:0] == 2'h0) && (i_hsize != 3'h7);
    assign wr_ctrl   = dp_wr_r && (dp_idx_r == awd_pkg::IDX_CTRL);
    assign win_clr   = (wr_ctrl && !i_hwdata[awd_pkg::CTRL_WIN_BIT])
                     || (dp_wr_r && dp_idx_r == awd_pkg::IDX_ICLR && i_hwdata[awd_pkg::EV_WIN]);
    assign done_clr  = (wr_ctrl && !i_hwdata[awd_pkg::CTRL_DONE_BIT])
                     || (dp_wr_r && dp_idx_r == awd_pkg::IDX_ICLR && i_hwdata[awd_pkg::EV_DONE]);

    function automatic logic [31:0] rd_word(input logic [9:0] idx);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (idx)
            awd_pkg::IDX_RESULT: w[7:0] = result_r;
            awd_pkg::IDX_CTRL: begin
                w[awd_pkg::CTRL_WIN_BIT]  = win_r;
                w[awd_pkg::CTRL_BUSY_BIT] = busy;
                w[awd_pkg::CTRL_DONE_BIT] = done_r;
            end
            awd_pkg::IDX_GT:    w[7:0] = gt_r;
            awd_pkg::IDX_LT:    w[7:0] = lt_r;
            awd_pkg::IDX_ISTAT: w[1:0] = {win_r, done_r};
            awd_pkg::IDX_IEN:   w[1:0] = ien_r;
            default:            w      = 32'h0000_0000;
        endcase
        return w;
    endfunction : rd_word

    // ------------------------------------------------------------
    // register next state
    // ------------------------------------------------------------
    always_comb begin
        dp_wr_nxt  = ap_valid && i_hwrite;
        dp_idx_nxt = ap_mapped ? i_haddr[11:2] : awd_pkg::IDX_NONE;
        hrdata_nxt = (ap_valid && !i_hwrite && ap_mapped) ? rd_word(i_haddr[11:2]) : 32'h0000_0000;
        gt_nxt     = gt_r;
        lt_nxt     = lt_r;
        ien_nxt    = ien_r;
        if (dp_wr_r && dp_idx_r == awd_pkg::IDX_GT) begin
            gt_nxt = i_hwdata[7:0];
        end
        if (dp_wr_r && dp_idx_r == awd_pkg::IDX_LT) begin
            lt_nxt = i_hwdata[7:0];
        end
        if (dp_wr_r && dp_idx_r == awd_pkg::IDX_IEN) begin
            ien_nxt = i_hwdata[1:0];
        end
        // a write of one while busy is dropped rather than restarting mid-conversion
        start_nxt  = wr_ctrl && i_hwdata[awd_pkg::CTRL_BUSY_BIT] && !busy && !start_r;
        result_nxt = conv.eoc ? conv.code : result_r;
        // set wins over a clear landing in the same cycle
        win_nxt    = (conv.eoc && match) || (win_r && !win_clr);
        done_nxt   = conv.eoc || (done_r && !done_clr);
        irq_nxt    = |({win_nxt, done_nxt} & ien_nxt);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            dp_wr_r  <= 1'b0;
            dp_idx_r <= awd_pkg::IDX_NONE;
            hrdata_r <= 32'h0000_0000;
            hready_r <= 1'b1;
            hresp_r  <= awd_pkg::HRESP_OKAY;
            gt_r     <= awd_pkg::LIMIT_RST;
            lt_r     <= awd_pkg::LIMIT_RST;
            result_r <= 8'h00;
            win_r    <= 1'b0;
            done_r   <= 1'b0;
            ien_r    <= awd_pkg::IEN_RST;
            irq_r    <= 1'b0;
            start_r  <= 1'b0;
        end else begin
            dp_wr_r  <= dp_wr_nxt;
            dp_idx_r <= dp_idx_nxt;
            hrdata_r <= hrdata_nxt;
            hready_r <= 1'b1;
            hresp_r  <= awd_pkg::HRESP_OKAY;
            gt_r     <= gt_nxt;
            lt_r     <= lt_nxt;
            result_r <= result_nxt;
            win_r    <= win_nxt;
            done_r   <= done_nxt;
            ien_r    <= ien_nxt;
            irq_r    <= irq_nxt;
            start_r  <= start_nxt;
        end
    end

    assign o_hrdata    = hrdata_r;
    assign o_hreadyout = hready_r;
    assign o_hresp     = hresp_r;
    assign o_irq       = irq_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    sequence s_wr_gt;
        ap_valid && i_hwrite && ap_mapped && i_haddr[11:2] == awd_pkg::IDX_GT;
    endsequence
    sequence s_rd_ctrl;
        ap_valid && !i_hwrite && ap_mapped && i_haddr[11:2] == awd_pkg::IDX_CTRL;
    endsequence
    sequence s_wr_lt;
        ap_valid && i_hwrite && ap_mapped && i_haddr[11:2] == awd_pkg::IDX_LT;
    endsequence
    // a result equal to either limit never matches, in either limit order
    sequence s_eoc_edge;
        conv.eoc && (conv.code == lt_r || conv.code == gt_r);
    endsequence
    sequence s_in_band;
        conv.eoc && lt_r > gt_r && conv.code > gt_r && conv.code < lt_r;
    endsequence
    sequence s_start_busy;
        wr_ctrl && i_hwdata[awd_pkg::CTRL_BUSY_BIT] && busy;
    endsequence

    chk_win_on_match: assert property (conv.eoc && match |=> win_r)
        else $error("matching result did not set window flag");
    chk_win_no_cause: assert property (!win_r && !(conv.eoc && match) |=> !win_r)
        else $error("window flag set without matching result");
    chk_win_sticky: assert property (win_r && !win_clr |=> win_r)
        else $error("window flag dropped without clear");
    chk_win_cleared: assert property (win_r && win_clr && !conv.eoc |=> !win_r)
        else $error("window flag not cleared by zero write");
    chk_irq_level: assert property (o_irq == |({win_r, done_r} & ien_r))
        else $error("interrupt level disagrees with enabled flags");
    chk_ctrl_read: assert property (s_rd_ctrl |=> o_hrdata[1] == $past(win_r))
        else $error("control read does not show window flag");
    chk_gt_write: assert property (s_wr_gt ##1 1'b1 |=> gt_r == $past(i_hwdata[7:0]))
        else $error("greater-than limit not loaded");
    chk_bus_okay: assert property (o_hreadyout && o_hresp == awd_pkg::HRESP_OKAY)
        else $error("slave not ready or not okay");
    chk_every_eoc: assert property (conv.eoc |=> result_r == $past(conv.code))
        else $error("result not captured at end of conversion");
    chk_result_hold: assert property (!conv.eoc |=> result_r == $past(result_r))
        else $error("result changed without conversion");
    chk_lt_write: assert property (s_wr_lt ##1 1'b1 |=> lt_r == $past(i_hwdata[7:0]))
        else $error("less-than limit not loaded");
    chk_win_strict: assert property (!win_r ##0 s_eoc_edge |=> !win_r)
        else $error("result equal to a limit set window flag");
    chk_win_in_band: assert property (s_in_band |=> win_r)
        else $error("in-band result with reversed limits missed");
    chk_irq_on_win: assert property (conv.eoc && match && ien_r[awd_pkg::EV_WIN] && !dp_wr_r |=> o_irq)
        else $error("enabled window event did not raise interrupt");
    chk_done_on_eoc: assert property (conv.eoc |=> done_r)
        else $error("end of conversion did not set done flag");

    // ------------------------------------------------------------
    // bus checks
    // ------------------------------------------------------------
    chk_start_busy: assert property (s_start_busy |=> !start_r)
        else $error("start accepted while busy");
    chk_rd_idle: assert property (!(ap_valid && !i_hwrite) |=> o_hrdata == 32'h0000_0000)
        else $error("read data outside data phase");
endmodule : awd_top

// ==== bench/test_adc_window_detector.sv ====
// self-checking bench for the window detector: registers, conversions, window flag, interrupt
`timescale 1ns/1ps
module test_adc_window_detector;
    logic        i_mclk;
    logic        i_nrst;
    logic        i_hsel;
    logic [31:0] i_haddr;
    logic [1:0]  i_htrans;
    logic        i_hwrite;
    logic [2:0]  i_hsize;
    logic [31:0] i_hwdata;
    logic [7:0]  i_ain_code;
    logic [31:0] o_hrdata;
    logic        o_hreadyout;
    logic [1:0]  o_hresp;
    logic        o_irq;
    int          errors;
    int          n_checks;
    int          cyc;
    int          m_gt;
    int          m_lt;
    int          m_win;
    int          m_done;
    int          m_ien;
    logic [31:0] seed;
    logic [7:0]  codes [6] = '{8'h0F, 8'h10, 8'h11, 8'h1F, 8'h20, 8'h21};

    awd_top uut (
        .i_mclk      (i_mclk),
        .i_nrst      (i_nrst),
        .i_hsel      (i_hsel),
        .i_haddr     (i_haddr),
        .i_htrans    (i_htrans),
        .i_hwrite    (i_hwrite),
        .i_hsize     (i_hsize),
        .i_hwdata    (i_hwdata),
        .i_hready    (o_hreadyout),
        .i_ain_code  (i_ain_code),
        .o_hrdata    (o_hrdata),
        .o_hreadyout (o_hreadyout),
        .o_hresp     (o_hresp),
        .o_irq       (o_irq)
    );

    // ------------------------------------------------------------
    // clock, cycle count, watchdog
    // ------------------------------------------------------------
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) cyc <= cyc + 1;
    // twenty-seven conversions of about 1300 cycles plus register traffic
    initial begin
        repeat (60000) @(posedge i_mclk);
        errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xorshift

    function automatic logic [31:0] addr(input logic [9:0] idx);
        return {20'h0, idx, 2'h0};
    endfunction : addr

    function automatic int win_hit(input int code);
        if (m_lt <= m_gt) return int'(code < m_lt || code > m_gt);
        return int'(code > m_gt && code < m_lt);
    endfunction : win_hit

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // one single transfer; address phase held until hready, data phase until hready
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_haddr <= a;
        i_hwrite <= wr;
        i_hsize <= 3'h2;
        do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
        i_htrans <= 2'h0;
        i_hsel <= 1'b0;
        i_hwdata <= wd;
        do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
        rd = o_hrdata;
        check("hresp", {30'h0, o_hresp}, {30'h0, awd_pkg::HRESP_OKAY});
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] r;
        bus(1'b1, a, wd, r);
    endtask : wr

    task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(what, r, exp);
    endtask : rdchk

    task automatic flags_chk();
        rdchk("istat", addr(awd_pkg::IDX_ISTAT), 32'(m_win * 2 + m_done));
        check("irq", {31'h0, o_irq}, 32'(((m_win * 2 + m_done) & m_ien) != 0));
    endtask : flags_chk

    // start by write, poll done; no per-conversion compare action from software
    task automatic conv(input logic [7:0] code);
        logic [31:0] r;
        int t0;
        i_ain_code <= code;
        repeat (4) @(posedge i_mclk);
        wr(addr(awd_pkg::IDX_CTRL), 32'h12);
        m_done = 0;
        t0 = cyc;
        @(posedge i_mclk);
        rdchk("busy", addr(awd_pkg::IDX_CTRL), 32'(32'h10 + m_win * 2));
        r = 32'h0;
        while (r[awd_pkg::CTRL_DONE_BIT] !== 1'b1) bus(1'b0, addr(awd_pkg::IDX_CTRL), 32'h0, r);
        check("conv_time", 32'((cyc - t0 >= awd_pkg::CONV_CYCLES) && (cyc - t0 <= awd_pkg::CONV_CYCLES + 12)), 1);
        m_done = 1;
        m_win = m_win | win_hit(int'(code));
        check("ctrl", r, 32'(32'h20 + m_win * 2));
        rdchk("result", addr(awd_pkg::IDX_RESULT), {24'h0, code});
        flags_chk();
    endtask : conv

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        n_checks = 0;
        seed = 32'h0000_F4CF;
        m_win = 0;
        m_done = 0;
        m_ien = 0;
        i_nrst = 1'b0;
        i_hsel = 1'b0;
        i_haddr = 32'h0;
        i_htrans = 2'h0;
        i_hwrite = 1'b0;
        i_hsize = 3'h2;
        i_hwdata = 32'h0;
        i_ain_code = 8'h00;
        repeat (4) @(posedge i_mclk);
        i_nrst <= 1'b1;
        @(posedge i_mclk);
        check("irq_rst", {31'h0, o_irq}, 32'h0);
        rdchk("ctrl_rst", addr(awd_pkg::IDX_CTRL), 32'h0);
        rdchk("gt_rst", addr(awd_pkg::IDX_GT), {24'h0, awd_pkg::LIMIT_RST});
        rdchk("lt_rst", addr(awd_pkg::IDX_LT), {24'h0, awd_pkg::LIMIT_RST});
        rdchk("ien_rst", addr(awd_pkg::IDX_IEN), {30'h0, awd_pkg::IEN_RST});
        wr(addr(awd_pkg::IDX_GT), 32'hFFFF_FFA5);
        rdchk("gt_rw", addr(awd_pkg::IDX_GT), 32'h0000_00A5);
        wr(addr(awd_pkg::IDX_LT) | 32'h0000_1000, 32'h0000_005A);
        rdchk("lt_unmapped_wr", addr(awd_pkg::IDX_LT), 32'h0);
        rdchk("unmapped_rd", addr(awd_pkg::IDX_GT) | 32'h0000_1000, 32'h0);
        rdchk("misaligned_rd", addr(awd_pkg::IDX_GT) | 32'h1, 32'h0);
        // both limit orders, boundary codes, sticky runs between clears
        // third pass has equal limits and both enables
        for (int mode = 0; mode < 3; mode++) begin
            m_lt = (mode == 0) ? 32'h10 : 32'h20;
            m_gt = (mode == 1) ? 32'h10 : 32'h20;
            m_ien = mode + 1;
            wr(addr(awd_pkg::IDX_LT), 32'(m_lt));
            wr(addr(awd_pkg::IDX_GT), 32'(m_gt));
            wr(addr(awd_pkg::IDX_IEN), 32'(m_ien));
            rdchk("ien_rw", addr(awd_pkg::IDX_IEN), 32'(m_ien));
            for (int i = 0; i < 9; i++) begin
                seed = xorshift(seed);
                conv((i < 6) ? codes[i] : seed[7:0]);
                if (i % 3 == 2) begin
                    // alternate the two ways of clearing the window flag
                    if (i % 2 == 1) wr(addr(awd_pkg::IDX_ICLR), 32'h2);
                    else wr(addr(awd_pkg::IDX_CTRL), 32'h20);
                    m_win = 0;
                    flags_chk();
                end
            end
        end
        tally_and_finish();
    end
endmodule : test_adc_window_detector
